// file: dv/test_tmo_timer.sv
// testbench: register access, counting, overflow interrupt, trigger and wide mode
`timescale 1ns/1ps
`default_nettype none
module test_tmo_timer import tmo_pkg::*;;
  localparam int unsigned DIV = 2;

  typedef struct packed {logic [7:0] adr; logic [7:0] wd; logic [7:0] ex;} tmo_row_s;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        ext_clk_i = 1'b0;
  logic        aux_osc_clk_i = 1'b0;
  logic        special_event_i = 1'b0;
  logic        aux_osc_en_o;
  logic        irq_o;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc_n = 0;
  tmo_row_s    rows [7];

  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n++;

  tmo_timer #(.DIV(DIV)) dut (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .wb_cyc_i       (wb_cyc_i),
    .wb_stb_i       (wb_stb_i),
    .wb_we_i        (wb_we_i),
    .wb_adr_i       (wb_adr_i),
    .wb_sel_i       (wb_sel_i),
    .wb_dat_i       (wb_dat_i),
    .wb_dat_o       (wb_dat_o),
    .wb_ack_o       (wb_ack_o),
    .ext_clk_i      (ext_clk_i),
    .aux_osc_clk_i  (aux_osc_clk_i),
    .special_event_i(special_event_i),
    .aux_osc_en_o   (aux_osc_en_o),
    .irq_o          (irq_o)
  );

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // counts that depend on tick phase are allowed one step of slack
  task automatic near(input logic [31:0] got, input int exp);
    checks++;
    if ($isunknown(got) || int'(got) > exp + 1 || int'(got) + 1 < exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // wishbone classic master
  // ---------------------------------------------------------------
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                     input logic evt, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i        <= 1'b1;
    wb_stb_i        <= 1'b1;
    wb_we_i         <= we;
    wb_adr_i        <= adr;
    wb_dat_i        <= {24'h0, dat};
    wb_sel_i        <= 4'hF;
    special_event_i <= evt;
    n = 0;
    do begin
      @(posedge clk_i);
      special_event_i <= 1'b0;
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t ack=%h exp=%h", $time, wb_ack_o, 1'b1);
      give_verdict();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [31:0] d;
    bus(1'b1, adr, dat, 1'b0, d);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    logic [31:0] d;
    bus(1'b0, adr, 8'h00, 1'b0, d);
    chk(d, {24'h0, exp});
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [7:0]  cv;
    int          t0;
    int          n;
    rows = '{'{OFF_CTRL, 8'h72, 8'h32}, '{OFF_LOW, 8'h5A, 8'h5A}, '{OFF_HIGH, 8'hA5, 8'hA5},
             '{OFF_MASK, 8'h01, 8'h01}, '{8'h14, 8'h77, 8'h00}, '{OFF_STAT, 8'h01, 8'h00},
             '{OFF_CTRL, 8'h00, 8'h00}};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({30'h0, aux_osc_en_o, irq_o}, 32'h0);
    rd(OFF_CTRL, CTRL_RST);
    rd(OFF_LOW, 8'h00);
    rd(OFF_HIGH, 8'h00);
    rd(OFF_STAT, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      wr(rows[i].adr, rows[i].wd);
      rd(rows[i].adr, rows[i].ex);
    end
    $display("test register rows done");
    // one pass per prescale code, internal clock
    for (int p = 0; p < 4; p++) begin
      cv = {2'b00, p[1:0], 4'h0};
      wr(OFF_CTRL, cv);
      wr(OFF_HIGH, 8'h00);
      wr(OFF_LOW, 8'h00);
      wr(OFF_CTRL, cv | 8'h01);
      t0 = cyc_n;
      repeat (160) @(posedge clk_i);
      wr(OFF_CTRL, cv);
      n = (cyc_n - t0) / (int'(DIV) << p);
      bus(1'b0, OFF_LOW, 8'h00, 1'b0, d);
      near(d, n);
      repeat (20) @(posedge clk_i);
      rd(OFF_LOW, d[7:0]);
    end
    $display("test prescale done");
    wr(OFF_MASK, 8'h01);
    wr(OFF_HIGH, 8'hFF);
    wr(OFF_LOW, 8'hFD);
    rd(OFF_STAT, 8'h00);
    wr(OFF_CTRL, 8'h01);
    n = 0;
    while (irq_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, irq_o}, 32'h1);
    wr(OFF_CTRL, 8'h00);
    rd(OFF_STAT, 8'h01);
    rd(OFF_HIGH, 8'h00);
    wr(OFF_MASK, 8'h00);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(OFF_MASK, 8'h01);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(OFF_STAT, 8'h01);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    rd(OFF_STAT, 8'h00);
    $display("test overflow done");
    wr(OFF_HIGH, 8'h12);
    wr(OFF_LOW, 8'h34);
    @(posedge clk_i);
    special_event_i <= 1'b1;
    @(posedge clk_i);
    special_event_i <= 1'b0;
    rd(OFF_LOW, 8'h00);
    rd(OFF_HIGH, 8'h00);
    bus(1'b1, OFF_LOW, 8'h33, 1'b1, d);
    rd(OFF_LOW, 8'h33);
    $display("test trigger done");
    wr(OFF_CTRL, 8'h80);
    wr(OFF_HIGH, 8'h12);
    wr(OFF_LOW, 8'h34);
    wr(OFF_HIGH, 8'h99);
    rd(OFF_LOW, 8'h34);
    rd(OFF_HIGH, 8'h12);
    wr(OFF_CTRL, 8'h00);
    rd(OFF_HIGH, 8'h12);
    $display("test wide access done");
    // synchronised, bypassed, then oscillator input
    for (int m = 0; m < 3; m++) begin
      cv = (m == 0) ? 8'h03 : (m == 1) ? 8'h07 : 8'h0F;
      wr(OFF_CTRL, cv & 8'hFE);
      wr(OFF_LOW, 8'h00);
      wr(OFF_HIGH, 8'h00);
      wr(OFF_CTRL, cv);
      chk({31'h0, aux_osc_en_o}, {31'h0, m == 2});
      repeat (5) begin
        if (m == 2) aux_osc_clk_i <= 1'b1;
        else ext_clk_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        aux_osc_clk_i <= 1'b0;
        ext_clk_i     <= 1'b0;
        repeat (3) @(posedge clk_i);
      end
      repeat (6) @(posedge clk_i);
      wr(OFF_CTRL, cv & 8'hFE);
      rd(OFF_LOW, 8'h05);
    end
    wr(OFF_CTRL, 8'h00);
    chk({31'h0, aux_osc_en_o}, 32'h0);
    $display("test external clock done");
    give_verdict();
  end
endmodule
`default_nettype wire

// file: hw/tmo_clk_src.sv
// clock source select, external input synchroniser and input prescaler
`timescale 1ns/1ps
`default_nettype none
module tmo_clk_src
  import tmo_pkg::*;
#(
  parameter int unsigned DIV = INSTR_DIV
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ext_clk_i,
  input  wire logic aux_osc_clk_i,
  tmo_core_if.src   core
);
  localparam int unsigned DW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

  logic [DW-1:0]    div_r;
  logic             sync1_r;
  logic             sync2_r;
  logic             sync3_r;
  logic             raw_prev_r;
  logic [PRE_W-1:0] pre_r;
  logic             pin;
  logic             int_tick;
  logic             ext_edge;
  logic             base;

  // ---------------------------------------------------------------
  // instruction-cycle tick
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || div_r == DIV_LAST) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DW'(1);
    end
  end
  assign int_tick = (div_r == DIV_LAST);

  // ---------------------------------------------------------------
  // external input: crystal pin when oscillator is on, else clock pin
  // ---------------------------------------------------------------
  assign pin = core.osc_en ? aux_osc_clk_i : ext_clk_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r    <= 1'b0;
      sync2_r    <= 1'b0;
      sync3_r    <= 1'b0;
      raw_prev_r <= 1'b0;
    end else begin
      sync1_r    <= pin;
      sync2_r    <= sync1_r;
      sync3_r    <= sync2_r;
      raw_prev_r <= pin;
    end
  end

  // bypass saves two cycles of latency, at the cost of no metastability guard
  assign ext_edge = core.sync_bypass ? (pin & ~raw_prev_r)
                                     : (sync2_r & ~sync3_r);
  assign base     = core.src_ext ? ext_edge : int_tick;

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || core.pre_clear) begin
      pre_r <= '0;
    end else if (base) begin
      pre_r <= core.tick ? '0 : pre_r + PRE_W'(1);
    end
  end
  assign core.tick = base && (pre_r == tmo_pre_last(core.prescale));

  chk_pre_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    core.pre_clear |=> pre_r == '0)
    else $error("prescaler not cleared");

  chk_tick_source: assert property (@(posedge clk_i) disable iff (rst_i)
    (!core.src_ext && !int_tick) |-> !core.tick)
    else $error("tick without instruction cycle");
endmodule
`default_nettype wire

// file: hw/tmo_core_if.sv
// interface: configuration, count tick and interrupt events between timer parts
`timescale 1ns/1ps
`default_nettype none
interface tmo_core_if #(parameter int unsigned N = 1);
  logic         src_ext;
  logic         sync_bypass;
  logic         osc_en;
  logic [1:0]   prescale;
  logic         pre_clear;
  logic         tick;
  logic [N-1:0] evt;
  logic [N-1:0] clr;
  logic [N-1:0] mask;
  logic [N-1:0] status;
  logic         irq;

  modport ctrl (output src_ext, sync_bypass, osc_en, prescale, pre_clear, evt, clr, mask,
                input  tick, status, irq);
  modport src  (input  src_ext, sync_bypass, osc_en, prescale, pre_clear, output tick);
  modport irqs (input  evt, clr, mask, output status, irq);
endinterface
`default_nettype wire

// file: hw/tmo_irq.sv
// sticky event status, write-one-to-clear, masked level interrupt
`timescale 1ns/1ps
`default_nettype none
module tmo_irq
  import tmo_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  tmo_core_if.irqs  core
);
  logic [NUM_EVT-1:0] status_r;
  logic [NUM_EVT-1:0] status_nxt;
  logic               irq_r;

  // set wins over a clear in the same cycle
  assign status_nxt = (status_r & ~core.clr) | core.evt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= STAT_RST;
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_r    <= |(status_nxt & core.mask);
    end
  end

  assign core.status = status_r;
  assign core.irq    = irq_r;

  chk_evt_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    core.evt[EVT_OVF] |=> core.status[EVT_OVF])
    else $error("overflow event not latched");

  chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 core.irq == |(core.status & $past(core.mask)))
    else $error("interrupt level does not match status and mask");
endmodule
`default_nettype wire

// file: hw/tmo_pkg.sv
// package: register map, field layout and reset values of the 16-bit timer/counter
package tmo_pkg;

  // ---------------------------------------------------------------
  // register byte offsets (one aligned 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LOW  = 8'h04;
  localparam logic [7:0] OFF_HIGH = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;

  // ---------------------------------------------------------------
  // timer_one_control fields
  // ---------------------------------------------------------------
  localparam int unsigned BIT_RUN  = 0;
  localparam int unsigned BIT_SRC  = 1;
  localparam int unsigned BIT_SYNC = 2;
  localparam int unsigned BIT_OSC  = 3;
  localparam int unsigned BIT_PS   = 4;
  localparam int unsigned BIT_NONE = 6;
  localparam int unsigned BIT_WIDE = 7;

  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  CTRL_WMASK = 8'hBF;

  // ---------------------------------------------------------------
  // counter, status and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [7:0]  HBUF_RST    = 8'h00;
  localparam int unsigned NUM_EVT     = 1;
  localparam int unsigned EVT_OVF     = 0;
  localparam logic [NUM_EVT-1:0] STAT_RST = 1'h0;
  localparam logic [NUM_EVT-1:0] MASK_RST = 1'h0;
  localparam int unsigned INSTR_DIV   = 4;
  localparam int unsigned PRE_W       = 3;

  // address match on the word index
  function automatic logic tmo_hit(input logic [7:0] adr, input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction

  // prescale code to terminal count: 00 -> 0, 01 -> 1, 10 -> 3, 11 -> 7
  function automatic logic [PRE_W-1:0] tmo_pre_last(input logic [1:0] code);
    return PRE_W'((4'h1 << code) - 4'h1);
  endfunction

endpackage

// file: hw/tmo_timer.sv
// top: 16-bit timer/counter with classic Wishbone register slave
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// register map (32-bit words, data in bits 7:0, upper bits read 0)
// ---------------------------------------------------------------
//   0x00 timer_one_control  RW  7 wide_access_enable, 6 reads 0,
//        5:4 prescale_select, 3 aux_oscillator_enable,
//        2 external_sync_bypass, 1 clock_source_select, 0 counter_run
//   0x04 count_low_byte     RW
//   0x08 count_high_byte    RW  (buffer when wide access is on)
//   0x0C status             W1C bit 0 overflow_flag
//   0x10 interrupt mask     RW  bit 0
//   others: ack, read 0, write ignored

module tmo_timer
  import tmo_pkg::*;
#(
  parameter int unsigned DIV = INSTR_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_clk_i,
  input  wire logic        aux_osc_clk_i,
  input  wire logic        special_event_i,
  output logic             aux_osc_en_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]         ctrl_r;
  logic [15:0]        count_r;
  logic [15:0]        count_nxt;
  logic [7:0]         hbuf_r;
  logic [NUM_EVT-1:0] mask_r;
  logic               ack_r;
  logic [31:0]        dat_r;
  logic [7:0]         rd_data;

  tmo_core_if #(.N(NUM_EVT)) core ();

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] wdat;
  logic       wide;
  logic       run;
  logic       wr_ctrl;
  logic       wr_low;
  logic       wr_high;
  logic       wr_stat;
  logic       wr_mask;
  logic       rd_low;
  logic       cnt_wr;
  logic       ovf;

  // the access is served in the cycle before ack, so ack comes one edge later
  assign acc     = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr      = acc && wb_we_i && wb_sel_i[0];
  assign rd      = acc && !wb_we_i;
  assign wdat    = wb_dat_i[7:0];
  assign wide    = ctrl_r[BIT_WIDE];
  assign run     = ctrl_r[BIT_RUN];
  assign wr_ctrl = wr && tmo_hit(wb_adr_i, OFF_CTRL);
  assign wr_low  = wr && tmo_hit(wb_adr_i, OFF_LOW);
  assign wr_high = wr && tmo_hit(wb_adr_i, OFF_HIGH);
  assign wr_stat = wr && tmo_hit(wb_adr_i, OFF_STAT);
  assign wr_mask = wr && tmo_hit(wb_adr_i, OFF_MASK);
  assign rd_low  = rd && tmo_hit(wb_adr_i, OFF_LOW);
  // in wide mode a high write only fills the buffer
  assign cnt_wr  = wr_low || (wr_high && !wide);

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= wdat & CTRL_WMASK;
    end
  end

  assign core.src_ext     = ctrl_r[BIT_SRC];
  assign core.sync_bypass = ctrl_r[BIT_SYNC];
  assign core.osc_en      = ctrl_r[BIT_OSC];
  assign core.prescale    = ctrl_r[BIT_PS +: 2];
  assign core.pre_clear   = wr_low;
  assign aux_osc_en_o     = ctrl_r[BIT_OSC];

  // ---------------------------------------------------------------
  // counter: write, then trigger, then count
  // ---------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    // write branch first so a coincident trigger is dropped
    if (wr_low) begin
      count_nxt = wide ? {hbuf_r, wdat} : {count_r[15:8], wdat};
    end else if (wr_high && !wide) begin
      count_nxt = {wdat, count_r[7:0]};
    end else if (special_event_i) begin
      count_nxt = CNT_RST;
    end else if (run && core.tick) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= CNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // trigger resets never raise the flag; only a real wrap does
  assign ovf = run && core.tick && count_r == CNT_MAX && !cnt_wr
               && !special_event_i;

  // ---------------------------------------------------------------
  // high byte buffer for wide access
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hbuf_r <= HBUF_RST;
    end else if (wide && wr_high) begin
      hbuf_r <= wdat;
    end else if (wide && rd_low) begin
      hbuf_r <= count_r[15:8];
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= MASK_RST;
    end else if (wr_mask) begin
      mask_r <= wdat[NUM_EVT-1:0];
    end
  end

  assign core.evt  = NUM_EVT'(ovf) << EVT_OVF;
  assign core.clr  = wr_stat ? wdat[NUM_EVT-1:0] : '0;
  assign core.mask = mask_r;
  assign irq_o     = core.irq;

  tmo_irq u_irq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .core  (core.irqs)
  );

  tmo_clk_src #(.DIV(DIV)) u_src (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ext_clk_i     (ext_clk_i),
    .aux_osc_clk_i (aux_osc_clk_i),
    .core          (core.src)
  );

  // ---------------------------------------------------------------
  // read mux and bus answer
  // ---------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    if (tmo_hit(wb_adr_i, OFF_CTRL)) begin
      rd_data = ctrl_r;
    end else if (tmo_hit(wb_adr_i, OFF_LOW)) begin
      rd_data = count_r[7:0];
    end else if (tmo_hit(wb_adr_i, OFF_HIGH)) begin
      rd_data = wide ? hbuf_r : count_r[15:8];
    end else if (tmo_hit(wb_adr_i, OFF_STAT)) begin
      rd_data = 8'(core.status);
    end else if (tmo_hit(wb_adr_i, OFF_MASK)) begin
      rd_data = 8'(mask_r);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (rd) begin
      dat_r <= {24'h00_0000, rd_data};
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_run_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!run && !cnt_wr && !special_event_i) |=> count_r == $past(count_r))
    else $error("counter moved while stopped");

  chk_event_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (special_event_i && !cnt_wr) |=> count_r == CNT_RST)
    else $error("special event did not clear counter");

  chk_write_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (special_event_i && wr_low) |=> count_r[7:0] == $past(wdat))
    else $error("trigger overrode software write");

  chk_ctrl_bit6: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> ctrl_r[BIT_NONE] == 1'b0 && ctrl_r[BIT_RUN] == $past(wdat[BIT_RUN]))
    else $error("control bit 6 or run bit wrong after write");

  chk_wide_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (wide && rd_low) |=> hbuf_r == $past(count_r[15:8]))
    else $error("high byte not buffered on low read");

  chk_wide_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (wide && wr_low) |=> count_r == {$past(hbuf_r), $past(wdat)})
    else $error("wide low write did not load both bytes");

  chk_osc_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> aux_osc_en_o == $past(wdat[BIT_OSC]))
    else $error("oscillator enable does not follow control bit");

  chk_wrap_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf |=> count_r == CNT_RST ##1 core.status[EVT_OVF])
    else $error("wrap did not zero counter and set flag");

  chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !ack_r) |=> ack_r ##1 !ack_r)
    else $error("ack not a single cycle after request");

endmodule
`default_nettype wire
